// file: design/srp_defs.svh
// constants of the serial register port: addresses, fields, resets, counts
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH

// =====================================================================
// instruction byte layout
`define SRP_INSTR_LAST 5'h07
`define SRP_INSTR_RW 7
`define SRP_INSTR_ADDR_MSB 4

// =====================================================================
// register addresses
`define SRP_ADDR_COMM 5'h00
`define SRP_ADDR_DCTL 5'h01
`define SRP_ADDR_DSYNC 5'h02
`define SRP_ADDR_MSYNC 5'h03
`define SRP_ADDR_FTW 5'h0a
`define SRP_ADDR_ASF 5'h0b

// =====================================================================
// register byte widths
`define SRP_BYTES_ONE 3'h1
`define SRP_BYTES_CTL 3'h2
`define SRP_BYTES_ASF 3'h3
`define SRP_BYTES_FTW 3'h4

// =====================================================================
// communication register fields and reset values
`define SRP_COMM_3WIRE 7
`define SRP_COMM_LSB 6
`define SRP_COMM_SWRST 5
`define SRP_COMM_RST 32'h0000_0002
`define SRP_DCTL_RST 32'h0000_3100
`define SRP_ZERO_RST 32'h0000_0000

// =====================================================================
// sclk rises with chip select high that restart the port
`define SRP_RESYNC_EDGES 8

`endif

// file: design/srp_pkg.sv
// types shared by the serial register port
package srp_pkg;

  // ===================================================================
  // port phase
  typedef enum logic [0:0]
  {
    SRP_ST_INSTR = 1'b0,
    SRP_ST_DATA = 1'b1
  } srp_state_t;

endpackage

// file: design/srp_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
module srp_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // =====================================================================
  // only the second stage is ever read outside this module
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

// file: design/srp_top.sv
// serial register port: instruction byte, whole-register data phase
`include "srp_defs.svh"

// Functional notes
// - a cycle opens with an eight-bit instruction on eight sclk rises
// - instruction gives read or write direction and target register
// - transfers always cover a whole register, never a single byte
// - data phase moves exactly the addressed register's byte count
// - tuning word register moves four data bytes
// - amplitude scale register moves three data bytes
// - the cycle ends once the last data bit is moved
// - after a cycle the next eight rises form a new instruction
// - instruction and write data are sampled on sclk rising edges
// - read data is launched on sclk falling edges
// - one shared data pin (3-wire) or separate in and out pins
// - msb-first and lsb-first transfer orders both supported
// - chip select lets only the selected device take part
// - every register is readable and writable through the port
// - instruction bit 7 read, bits 6..5 ignored, bits 4..0 address
// - deselect floats both outputs and pauses the cycle in place
// - comm bit 6 picks lsb-first order for instruction and data
// - eight or more sclk rises while deselected restart the port
module srp_top
  import srp_pkg::*;
#(
  parameter int NUM_REGS = 32,
  parameter int RESYNC_EDGES = `SRP_RESYNC_EDGES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_n_o,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  output logic wr_strobe_o,
  output logic [4:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic lsb_first_o,
  output logic three_wire_o
);

  localparam int CNT_W = $clog2(RESYNC_EDGES + 1);

  // =====================================================================
  // elaboration checks
  if (NUM_REGS < 12 || NUM_REGS > 32)
  begin : g_bad_regs
    $error("srp_top: NUM_REGS must lie in 12..32");
  end
  if (RESYNC_EDGES < 1)
  begin : g_bad_resync
    $error("srp_top: RESYNC_EDGES must be at least 1");
  end

  // =====================================================================
  // per-register width and reset value
  function automatic logic [2:0] bytes_of(input logic [4:0] a);
    logic [2:0] b;
    b = `SRP_BYTES_ONE;
    case (a)
      `SRP_ADDR_DCTL: b = `SRP_BYTES_CTL;
      `SRP_ADDR_DSYNC: b = `SRP_BYTES_CTL;
      `SRP_ADDR_MSYNC: b = `SRP_BYTES_CTL;
      `SRP_ADDR_FTW: b = `SRP_BYTES_FTW;
      `SRP_ADDR_ASF: b = `SRP_BYTES_ASF;
      default: b = `SRP_BYTES_ONE;
    endcase
    return b;
  endfunction

  function automatic logic [31:0] rst_of(input logic [4:0] a);
    logic [31:0] v;
    v = `SRP_ZERO_RST;
    case (a)
      `SRP_ADDR_COMM: v = `SRP_COMM_RST;
      `SRP_ADDR_DCTL: v = `SRP_DCTL_RST;
      default: v = `SRP_ZERO_RST;
    endcase
    return v;
  endfunction

  // =====================================================================
  // pin synchronisers and sclk edge detection
  logic [2:0] pin_s;
  logic sclk_d_reg;
  srp_sync #(
    .WIDTH(3),
    .RST_VAL(3'h2)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({sclk_i, cs_n_i, sdio_i}),
    .sync_o(pin_s)
  );

  wire sclk_s = pin_s[2];
  wire cs_n_s = pin_s[1];
  wire sdi_s = pin_s[0];
  wire rise_w = sclk_s & ~sclk_d_reg;
  wire fall_w = ~sclk_s & sclk_d_reg;
  wire srise_w = rise_w & ~cs_n_s;
  wire sfall_w = fall_w & ~cs_n_s;

  // =====================================================================
  // state
  srp_state_t state_reg;
  srp_state_t state_next;
  logic [4:0] bit_idx_reg;
  logic [4:0] bit_idx_next;
  logic [4:0] out_idx_reg;
  logic [7:0] instr_reg;
  logic rw_reg;
  logic [4:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic dout_reg;
  logic [CNT_W-1:0] resync_reg;
  logic swrst_reg;
  logic [31:0] reg_arr [NUM_REGS];

  // =====================================================================
  // decode: bit order, instruction fields, data phase length
  wire three_wire_w = reg_arr[0][`SRP_COMM_3WIRE];
  wire lsb_w = reg_arr[0][`SRP_COMM_LSB];
  wire [2:0] ipos_w = lsb_w ? bit_idx_reg[2:0] : ~bit_idx_reg[2:0];
  logic [7:0] instr_word_w;
  always_comb
  begin
    instr_word_w = instr_reg;
    instr_word_w[ipos_w] = sdi_s;
  end
  wire instr_rw_w = instr_word_w[`SRP_INSTR_RW];
  wire [4:0] instr_addr_w = instr_word_w[`SRP_INSTR_ADDR_MSB:0];
  wire [2:0] nbytes_w = bytes_of(addr_reg);
  wire [1:0] nb_m1_w = 2'(nbytes_w - 3'h1);
  wire [4:0] last_idx_w = {nb_m1_w, 3'h7};
  // lsb-first sends the low byte first, so index equals bit position
  wire [4:0] dpos_w = lsb_w ? bit_idx_reg : last_idx_w - bit_idx_reg;
  wire [4:0] opos_w = lsb_w ? out_idx_reg : last_idx_w - out_idx_reg;
  wire mapped_w = {1'b0, instr_addr_w} < 6'(NUM_REGS);
  wire [31:0] rd_word_w = mapped_w ? reg_arr[instr_addr_w] : '0;
  logic [31:0] wr_word_w;
  always_comb
  begin
    wr_word_w = wdata_reg;
    wr_word_w[dpos_w] = sdi_s;
  end
  wire in_instr_w = state_reg == SRP_ST_INSTR;
  wire in_data_w = state_reg == SRP_ST_DATA;
  wire instr_done_w = srise_w & in_instr_w & (bit_idx_reg == `SRP_INSTR_LAST);
  wire data_done_w = srise_w & in_data_w & (bit_idx_reg == last_idx_w);
  wire wr_commit_w = data_done_w & ~rw_reg;
  wire resync_hit_w = cs_n_s & rise_w
    & (resync_reg == CNT_W'(RESYNC_EDGES - 1));
  wire drive_w = ~cs_n_s & in_data_w & rw_reg;

  // =====================================================================
  // phase sequencing; a deselect freezes the phase until reselect, or until RESYNC_EDGES sclk rises restart it
  always_comb
  begin
    state_next = state_reg;
    bit_idx_next = bit_idx_reg;
    if (resync_hit_w)
    begin
      state_next = SRP_ST_INSTR;
      bit_idx_next = '0;
    end
    else if (instr_done_w)
    begin
      state_next = SRP_ST_DATA;
      bit_idx_next = '0;
    end
    else if (data_done_w)
    begin
      state_next = SRP_ST_INSTR;
      bit_idx_next = '0;
    end
    else if (srise_w)
    begin
      bit_idx_next = bit_idx_reg + 5'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= SRP_ST_INSTR;
      bit_idx_reg <= '0;
      sclk_d_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      bit_idx_reg <= bit_idx_next;
      sclk_d_reg <= sclk_s;
    end
  end

  // =====================================================================
  // instruction and write data capture on rising edges
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      instr_reg <= '0;
      rw_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
    end
    else if (instr_done_w)
    begin
      instr_reg <= '0;
      rw_reg <= instr_rw_w;
      addr_reg <= instr_addr_w;
      wdata_reg <= '0;
      rdata_reg <= rd_word_w;
    end
    else if (srise_w && in_instr_w)
    begin
      instr_reg <= instr_word_w;
    end
    else if (srise_w && in_data_w)
    begin
      wdata_reg <= wr_word_w;
    end
  end

  // =====================================================================
  // read data launch on falling edges, output enables per wiring mode
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      out_idx_reg <= '0;
      dout_reg <= 1'b0;
      sdio_oe_n_o <= 1'b1;
      sdo_oe_n_o <= 1'b1;
    end
    else
    begin
      if (instr_done_w)
        out_idx_reg <= '0;
      else if (sfall_w && in_data_w && rw_reg)
      begin
        dout_reg <= rdata_reg[opos_w];
        out_idx_reg <= out_idx_reg + 5'h01;
      end
      sdio_oe_n_o <= ~(drive_w & three_wire_w);
      sdo_oe_n_o <= ~(drive_w & ~three_wire_w);
    end
  end

  assign sdio_o = dout_reg;
  assign sdo_o = dout_reg;

  // =====================================================================
  // resync counter: counts rises only while deselected
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !cs_n_s)
      resync_reg <= '0;
    else if (rise_w && !resync_hit_w)
      resync_reg <= resync_reg + CNT_W'(1);
  end

  // =====================================================================
  // register file, written only as a whole word at the end of a cycle
  for (genvar g = 0; g < NUM_REGS; g++)
  begin : g_reg
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i || swrst_reg)
        reg_arr[g] <= rst_of(5'(g));
      else if (wr_commit_w && addr_reg == 5'(g))
        reg_arr[g] <= wr_word_w;
    end
  end

  // =====================================================================
  // write notification to the core and soft reset pulse
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_strobe_o <= 1'b0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
      swrst_reg <= 1'b0;
      lsb_first_o <= 1'b0;
      three_wire_o <= 1'b0;
    end
    else
    begin
      wr_strobe_o <= wr_commit_w;
      if (wr_commit_w)
      begin
        wr_addr_o <= addr_reg;
        wr_data_o <= wr_word_w;
      end
      // soft reset self-clears because the write commit it follows lasts one clock
      swrst_reg <= wr_commit_w && (addr_reg == `SRP_ADDR_COMM)
        && wr_word_w[`SRP_COMM_SWRST];
      lsb_first_o <= lsb_w;
      three_wire_o <= three_wire_w;
    end
  end

  // =====================================================================
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_instr_len: assert property (instr_done_w && !resync_hit_w
    |=> in_data_w && bit_idx_reg == 5'h00)
    else $error("instruction phase did not end after eight rises");
  chk_decode_rw: assert property (instr_done_w
    |=> rw_reg == $past(instr_rw_w) && addr_reg == $past(instr_addr_w))
    else $error("instruction fields not decoded");
  chk_data_len: assert property (data_done_w && !resync_hit_w
    |=> in_instr_w && bit_idx_reg == 5'h00)
    else $error("cycle did not end after last data bit");
  chk_ftw_len: assert property (in_data_w && addr_reg == `SRP_ADDR_FTW
    |-> last_idx_w == 5'h1f)
    else $error("tuning word length is not four bytes");
  chk_asf_len: assert property (in_data_w && addr_reg == `SRP_ADDR_ASF
    |-> last_idx_w == 5'h17)
    else $error("scale factor length is not three bytes");
  chk_cs_hiz: assert property (cs_n_s
    |=> sdio_oe_n_o && sdo_oe_n_o)
    else $error("output driven while deselected");
  chk_pause_hold: assert property (cs_n_s && !resync_hit_w
    |=> $stable(bit_idx_reg) && $stable(state_reg))
    else $error("cycle advanced while deselected");
  chk_resync_go: assert property (resync_hit_w
    |=> in_instr_w && bit_idx_reg == 5'h00)
    else $error("resync did not restart the port");
  chk_three_sdo: assert property (three_wire_w |=> sdo_oe_n_o)
    else $error("separate output driven in 3-wire mode");
  chk_launch_fall: assert property (!sfall_w |=> $stable(dout_reg))
    else $error("read data changed off a falling edge");
  chk_write_once: assert property (wr_commit_w
    |=> wr_strobe_o && wr_addr_o == $past(addr_reg) ##1 !wr_strobe_o)
    else $error("whole-register write not reported");

  cov_read_cycle: cover property (instr_done_w && instr_rw_w);
  cov_ftw_write: cover property (wr_commit_w
    && addr_reg == `SRP_ADDR_FTW);
  cov_resync: cover property (resync_hit_w);
  cov_pause: cover property (in_data_w && cs_n_s ##1 !cs_n_s);

endmodule

// file: verif/srp_host_model.sv
// serial master model that drives the register port pins
module srp_host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic sdio_i,
  input wire logic sdo_oe_n_i,
  input wire logic sdio_oe_n_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdio_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lsb = 1'b0;
  logic tw = 1'b0;
  int cut = -1;
  int pause = -1;
  int oe_bad = 0;

  // =====================================================================
  // pin idle levels: sclk starts low; each frame ends with it low, but toggle leaves it high
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdio_o = 1'b0;
  end

  // wait n system clocks, landing just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // sclk toggles with cs high; eight of them restart the port
  task automatic toggle(input int n);
    repeat (n)
    begin
      sclk_o = 1'b0;
      tick(4);
      sclk_o = 1'b1;
      tick(4);
    end
  endtask

  // =====================================================================
  // one frame: instruction then nb data bytes, optional pause or cut
  task automatic xfer(input logic [7:0] ins, input int nb,
    input logic [31:0] wd, output logic [31:0] rd);
    int k;
    logic b;
    logic rdp;
    rd = '0;
    cs_n_o = 1'b0;
    tick(4);
    for (int i = 0; i < 8 + nb * 8 && i != cut; i++)
    begin
      k = (i < 8) ? i : i - 8;
      rdp = ins[7] && i >= 8;
      if (i == pause)
      begin
        cs_n_o = 1'b1;
        tick(6);
        if (!sdo_oe_n_i || !sdio_oe_n_i) oe_bad++;
        toggle(3);
        cs_n_o = 1'b0;
        tick(4);
      end
      sclk_o = 1'b0;
      tick(2);
      // order follows the lsb flag for instruction and data alike
      b = (i < 8) ? ins[lsb ? k : 7 - k] : wd[lsb ? k : nb * 8 - 1 - k];
      // released line in a read phase does not hold its last level
      sdio_o = rdp ? ~sdio_o : b;
      tick(2);
      sclk_o = 1'b1;
      if (rdp)
      begin
        rd[lsb ? k : nb * 8 - 1 - k] = tw ? sdio_i : sdo_i;
        if (tw == sdio_oe_n_i || tw != sdo_oe_n_i) oe_bad++;
      end
      tick(4);
    end
    sclk_o = 1'b0;
    tick(2);
    cs_n_o = 1'b1;
    sdio_o = ~sdio_o;
    // short deselect gap so back-to-back frames never flip select twice
    tick(2);
  endtask
endmodule

// file: verif/test_srp_top.sv
// self-checking bench of the serial register port
`include "srp_defs.svh"
module test_srp_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i;
  logic rst_n_i;
  logic sclk;
  logic cs_n;
  logic hd;
  logic sdio_q;
  logic sdio_oe_n;
  logic sdo;
  logic sdo_oe_n;
  logic wr_stb;
  logic lsb_q;
  logic tw_q;
  logic [4:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] junk;
  logic [36:0] exp_q[$];
  logic [31:0] regs[32];
  logic [31:0] lf = 32'hebc3c860;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // the shared pin carries the device while it drives, else the host
  wire sdio_w = !sdio_oe_n ? sdio_q : hd;

  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;

  srp_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .sdio_i(sdio_w), .sdio_o(sdio_q),
    .sdio_oe_n_o(sdio_oe_n), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
    .wr_strobe_o(wr_stb), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .lsb_first_o(lsb_q), .three_wire_o(tw_q));

  srp_host_model host (.clk_i(clk_i), .sdo_i(sdo), .sdio_i(sdio_w),
    .sdo_oe_n_i(sdo_oe_n), .sdio_oe_n_i(sdio_oe_n), .sclk_o(sclk),
    .cs_n_o(cs_n), .sdio_o(hd));

  // =====================================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic int nbytes(input logic [4:0] a);
    if (a == `SRP_ADDR_COMM) return 1;
    if (a == `SRP_ADDR_FTW) return 4;
    if (a == `SRP_ADDR_ASF) return 3;
    return (a <= `SRP_ADDR_MSYNC) ? 2 : 1;
  endfunction

  task automatic defaults();
    foreach (regs[i]) regs[i] = `SRP_ZERO_RST;
    regs[0] = `SRP_COMM_RST;
    regs[1] = `SRP_DCTL_RST;
  endtask

  // a write notes its expected strobe before the frame goes out
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
    input logic [1:0] x);
    int n;
    logic [31:0] r;
    n = nbytes(a);
    d = (n == 4) ? d : d & ((32'h1 << (n * 8)) - 32'h1);
    exp_q.push_back({a, d});
    regs[a] = d;
    host.xfer({1'b0, x, a}, n, d, r);
  endtask

  task automatic rd(input logic [4:0] a);
    logic [31:0] r;
    lf = nxt(lf);
    host.xfer({1'b1, 2'b00, a}, nbytes(a), lf, r);
    chk("read data", regs[a], r);
    chk("enable faults", 32'h0, host.oe_bad);
  endtask

  task automatic rnd_wr_rd(input logic [4:0] a);
    lf = nxt(lf);
    wr(a, lf, 2'b00);
    rd(a);
  endtask

  task automatic report_and_stop();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // =====================================================================
  // watcher: each write strobe takes the oldest note off the queue
  always @(negedge clk_i)
    if (wr_stb === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("stray strobe", 32'h0, 32'h1);
      else
      begin
        chk("write addr", exp_q[0][36:32], wr_addr);
        chk("write data", exp_q[0][31:0], wr_data);
        void'(exp_q.pop_front());
      end
    end

  // hang guard, well above the length of the sequence below
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  // =====================================================================
  // main sequence
  initial
  begin
    rst_n_i = 1'b0;
    defaults();
    repeat (8) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    host.tick(4);
    for (int a = 0; a < 4; a++) rd(a[4:0]);
    $display("done: reset values");
    for (int a = 1; a < 32; a++) rnd_wr_rd(a[4:0]);
    wr(`SRP_ADDR_ASF, 32'h00a5c3e1, 2'b11);
    rd(`SRP_ADDR_ASF);
    $display("done: all registers msb first");
    wr(`SRP_ADDR_COMM, 32'h40, 2'b00);
    host.lsb = 1'b1;
    host.tick(4);
    chk("lsb flag", 32'h1, {31'h0, lsb_q});
    rnd_wr_rd(`SRP_ADDR_FTW);
    rnd_wr_rd(`SRP_ADDR_ASF);
    wr(`SRP_ADDR_COMM, 32'h60, 2'b00);
    defaults();
    host.lsb = 1'b0;
    host.tick(4);
    chk("lsb flag", 32'h0, {31'h0, lsb_q});
    rd(`SRP_ADDR_COMM);
    $display("done: lsb first");
    wr(`SRP_ADDR_COMM, 32'h80, 2'b00);
    host.tw = 1'b1;
    host.tick(4);
    chk("three wire flag", 32'h1, {31'h0, tw_q});
    rnd_wr_rd(`SRP_ADDR_FTW);
    $display("done: three wire");
    host.pause = 13;
    rnd_wr_rd(`SRP_ADDR_ASF);
    host.pause = 20;
    rd(`SRP_ADDR_FTW);
    host.pause = -1;
    $display("done: select pause");
    host.cut = 5;
    host.xfer(8'h0a, 4, 32'h0, junk);
    host.cut = -1;
    host.toggle(8);
    rnd_wr_rd(`SRP_ADDR_FTW);
    $display("done: resync");
    host.tick(20);
    chk("pending writes", 32'h0, exp_q.size());
    report_and_stop();
  end
endmodule
